// ### hw/tmc_top.sv
// Timer counter with modulo, coherent read buffer and channel zero flag
//
// Notes on behaviour
// - Byte read latches counter pair until opposite read
// - Reset, counter write, status write release buffer
// - Any counter byte write clears whole counter
// - Reset clears the counter
// - Debug halt freezes counter and read buffer
// - At modulo: flag, wrap or turn down
// - Half-written modulo suppresses overflow flag
// - Modulo resets zero; zero means free running
// - Capture mode: active pin edge sets flag
// - Compare or edge PWM: match sets flag
// - Center PWM: every match sets flag
// - Channel request while flag and enable set
// - Read-then-write-zero clears flag; one ignored
// - New event during clear sequence keeps flag
// - Reset clears channel flag and enable
// - Center select switches to up/down counting
// - Overflow flag cleared by read then zero
// - Overflow request while flag and enable set
`timescale 1ns/1ps
`include "tmc_consts.svh"

module tmc_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              CORE_CLK_IN,
    input  wire logic              NRST_IN,
    input  wire logic              CE_IN,
    input  wire logic              PSEL_IN,
    input  wire logic              PENABLE_IN,
    input  wire logic              PWRITE_IN,
    input  wire logic [ADDR_W-1:0] PADDR_IN,
    input  wire logic [31:0]       PWDATA_IN,
    input  wire logic              DEBUG_HALT_IN,
    input  wire logic              CH0_PIN_IN,
    output logic                   PREADY_OUT,
    output logic [31:0]            PRDATA_OUT,
    output logic                   PSLVERR_OUT,
    output logic                   OVF_IRQ_OUT,
    output logic                   CH0_IRQ_OUT
);

    ////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // True when the address selects the register at this index
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0]        idx);
        return a == ADDR_W'({idx, 2'b00});
    endfunction

    // Channel mode from center select and mode bits
    function automatic tmc_pkg::tmc_chmode_t mode_of(input logic cp,
                                                     input logic [1:0] ms);
        if (cp) begin
            return tmc_pkg::TMC_CH_CENTER;
        end else if (ms == 2'b00) begin
            return tmc_pkg::TMC_CH_CAPTURE;
        end else begin
            return tmc_pkg::TMC_CH_COMPARE;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // State

    logic [15:0]        cnt_q;       // Live counter
    tmc_pkg::tmc_dir_t  dir_q;       // Up or down phase
    logic [15:0]        buf_q;       // Coherent read buffer
    logic               latched_q;   // Buffer holds a frozen pair
    logic               first_hi_q;  // High byte opened the pair
    logic [15:0]        mod_q;       // Modulo value
    logic [1:0]         mod_wait_q;  // One modulo byte still missing
    logic [6:0]         sc_q;        // Status control, flag excluded
    logic               tof_q;       // Overflow flag
    logic               tof_arm_q;   // Overflow clear armed by read
    logic [4:0]         c0_q;        // Enable, mode and edge bits
    logic               channel_zero_event_flag_q;      // Channel zero event flag
    logic               ch_arm_q;    // Channel clear armed by read
    logic [15:0]        chv_q;       // Channel value
    logic               pin_q;       // Previous pin sample
    logic               moved_q;     // Counter stepped last cycle
    logic               snap_v_q;    // Read data captured for transfer
    logic [15:0]        snap_q;      // Counter seen with read data
    logic [31:0]        prdata_q;    // Registered read data

    ////////////////////////////////////////////////////////////////////
    // Bus decode

    logic       done;        // Transfer completes this edge
    logic       wr;          // Write takes effect
    logic       rd;          // Read completes
    logic       mapped;      // Address hits a register
    logic [7:0] rd_byte;     // Read value of addressed register
    logic [7:0] wd;          // Written byte
    logic       halt;        // Debug halt active
    logic       cnt_wr;      // Write to either counter byte
    logic       sc_wr;       // Write to status control
    logic       c0_wr;       // Write to channel control
    logic [15:0] cnt_view;   // Counter as software sees it

    assign halt   = DEBUG_HALT_IN;
    assign wd     = PWDATA_IN[7:0];
    // Reads wait one edge only if the setup edge was frozen out
    assign PREADY_OUT = CE_IN && (PWRITE_IN || snap_v_q);
    assign done   = PSEL_IN && PENABLE_IN && PREADY_OUT;
    assign wr     = done && PWRITE_IN;
    assign rd     = done && !PWRITE_IN;
    assign cnt_wr = wr && (hit(PADDR_IN, `TMC_IDX_CNT_HI) ||
                           hit(PADDR_IN, `TMC_IDX_CNT_LO));
    assign sc_wr  = wr && hit(PADDR_IN, `TMC_IDX_SC);
    assign c0_wr  = wr && hit(PADDR_IN, `TMC_IDX_C0SC);
    assign mapped = (PADDR_IN[1:0] == 2'b00) &&
                    (PADDR_IN[ADDR_W-1:2] >= (ADDR_W-2)'(`TMC_IDX_SC)) &&
                    (PADDR_IN[ADDR_W-1:2] <= (ADDR_W-2)'(`TMC_IDX_C0V_LO));
    assign PSLVERR_OUT = done && !mapped;
    assign PRDATA_OUT  = prdata_q;

    // Frozen pair wins over the live counter
    assign cnt_view = latched_q ? buf_q : cnt_q;

    // Read multiplexer, unmapped and reserved bits read zero
    always_comb begin
        rd_byte = `TMC_RST_BYTE;
        if (hit(PADDR_IN, `TMC_IDX_SC)) begin
            rd_byte = {tof_q, sc_q};
        end else if (hit(PADDR_IN, `TMC_IDX_CNT_HI)) begin
            rd_byte = cnt_view[15:8];
        end else if (hit(PADDR_IN, `TMC_IDX_CNT_LO)) begin
            rd_byte = cnt_view[7:0];
        end else if (hit(PADDR_IN, `TMC_IDX_MOD_HI)) begin
            rd_byte = mod_q[15:8];
        end else if (hit(PADDR_IN, `TMC_IDX_MOD_LO)) begin
            rd_byte = mod_q[7:0];
        end else if (hit(PADDR_IN, `TMC_IDX_C0SC)) begin
            rd_byte = {channel_zero_event_flag_q, c0_q, 2'b00};
        end else if (hit(PADDR_IN, `TMC_IDX_C0V_HI)) begin
            rd_byte = chv_q[15:8];
        end else if (hit(PADDR_IN, `TMC_IDX_C0V_LO)) begin
            rd_byte = chv_q[7:0];
        end
    end

    // Read data and counter snapshot taken together, so the buffer
    // later holds exactly the pair the first byte came from
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            snap_v_q <= 1'b0;
            snap_q   <= `TMC_RST_WORD;
            prdata_q <= '0;
        end else if (CE_IN) begin
            if (PSEL_IN && !PWRITE_IN && !snap_v_q) begin
                snap_v_q <= 1'b1;
                snap_q   <= cnt_q;
                prdata_q <= {24'h00_0000, rd_byte};
            end else if (done) begin
                snap_v_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Counter

    logic        tick;     // Prescaled step
    logic        center_aligned_select;    // Center-aligned select
    logic [15:0] limit;    // Turning point
    logic        reach;    // Counter at turning point
    logic        ovf_evt;  // Overflow event this edge

    assign center_aligned_select = sc_q[`TMC_SC_CENTER_ALIGNED_SELECT];
    assign limit = (mod_q == `TMC_RST_WORD) ? `TMC_CNT_FULL : mod_q;
    assign reach = (cnt_q == limit);
    // Center mode flags at the turn toward the next lower count
    assign ovf_evt = tick && reach && !cnt_wr && (mod_wait_q == 2'b00)
                     && (!center_aligned_select || dir_q == tmc_pkg::TMC_UP);

    // Any nonzero source select runs from the bus clock here
    tmc_tick u_tick (
        .clk_in   (CORE_CLK_IN),
        .nrst_in  (NRST_IN),
        .ce_in    (CE_IN),
        .run_in   ((sc_q[`TMC_SC_CLKS_HI:`TMC_SC_CLKS_LO] != 2'b00)
                   && !halt),
        .ps_in    (sc_q[`TMC_SC_PS_HI:0]),
        .tick_out (tick)
    );

    // Count up, or up and down in center mode
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            cnt_q <= `TMC_RST_WORD;
            dir_q <= tmc_pkg::TMC_UP;
        end else if (CE_IN) begin
            if (cnt_wr) begin
                cnt_q <= `TMC_RST_WORD;
                dir_q <= tmc_pkg::TMC_UP;
            end else if (tick && !halt) begin
                if (!center_aligned_select) begin
                    // Up only: wrap to zero after the limit
                    cnt_q <= reach ? `TMC_RST_WORD
                                   : cnt_q + `TMC_CNT_ONE;
                    dir_q <= tmc_pkg::TMC_UP;
                end else if (dir_q == tmc_pkg::TMC_UP) begin
                    if (reach) begin
                        dir_q <= tmc_pkg::TMC_DOWN;
                        cnt_q <= cnt_q - `TMC_CNT_ONE;
                    end else begin
                        cnt_q <= cnt_q + `TMC_CNT_ONE;
                    end
                end else if (cnt_q == `TMC_RST_WORD) begin
                    dir_q <= tmc_pkg::TMC_UP;
                    cnt_q <= `TMC_CNT_ONE;
                end else begin
                    cnt_q <= cnt_q - `TMC_CNT_ONE;
                end
            end
        end
    end

    // Marks the cycle after a step, for the compare match
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            moved_q <= 1'b0;
        end else if (CE_IN) begin
            moved_q <= tick && !halt && !cnt_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Coherent read buffer

    logic rd_hi;   // Counter high byte read
    logic rd_lo;   // Counter low byte read

    assign rd_hi = rd && hit(PADDR_IN, `TMC_IDX_CNT_HI);
    assign rd_lo = rd && hit(PADDR_IN, `TMC_IDX_CNT_LO);

    // Reads during halt leave the buffer untouched
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            latched_q  <= 1'b0;
            first_hi_q <= 1'b0;
            buf_q      <= `TMC_RST_WORD;
        end else if (CE_IN) begin
            if (cnt_wr || sc_wr) begin
                latched_q <= 1'b0;
            end else if (!halt && (rd_hi || rd_lo)) begin
                if (!latched_q) begin
                    latched_q  <= 1'b1;
                    first_hi_q <= rd_hi;
                    buf_q      <= snap_q;
                end else if (first_hi_q != rd_hi) begin
                    latched_q <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Modulo and status control

    logic wr_mod_hi;   // Modulo high byte write
    logic wr_mod_lo;   // Modulo low byte write

    assign wr_mod_hi = wr && hit(PADDR_IN, `TMC_IDX_MOD_HI);
    assign wr_mod_lo = wr && hit(PADDR_IN, `TMC_IDX_MOD_LO);

    // Byte writes; the missing byte keeps overflow quiet meanwhile
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            mod_q      <= `TMC_RST_WORD;
            mod_wait_q <= 2'b00;
            sc_q       <= 7'h00;
        end else if (CE_IN) begin
            if (wr_mod_hi) begin
                mod_q[15:8] <= wd;
                mod_wait_q  <= mod_wait_q[1] ? 2'b00 : 2'b01;
            end
            if (wr_mod_lo) begin
                mod_q[7:0] <= wd;
                mod_wait_q <= mod_wait_q[0] ? 2'b00 : 2'b10;
            end
            if (sc_wr) begin
                sc_q <= wd[6:0];
            end
        end
    end

    // Overflow flag: set wins over the armed clear
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            tof_q     <= 1'b0;
            tof_arm_q <= 1'b0;
        end else if (CE_IN) begin
            if (ovf_evt) begin
                tof_q <= 1'b1;
            end else if (sc_wr && !wd[`TMC_SC_TOF] && tof_arm_q) begin
                tof_q <= 1'b0;
            end
            if (ovf_evt || sc_wr) begin
                tof_arm_q <= 1'b0;
            end else if (rd && hit(PADDR_IN, `TMC_IDX_SC) && tof_q) begin
                tof_arm_q <= 1'b1;
            end
        end
    end

    assign OVF_IRQ_OUT = tof_q && sc_q[`TMC_SC_OVERFLOW_INTERRUPT_ENABLE];

    ////////////////////////////////////////////////////////////////////
    // Channel zero

    tmc_pkg::tmc_chmode_t mode;  // Decoded channel mode
    logic [1:0] els;             // Edge select bits
    logic       cap_evt;         // Capture edge
    logic       ch_evt;          // Any channel event

    assign mode = mode_of(center_aligned_select, c0_q[`TMC_C0_MS_HI-2:`TMC_C0_MS_LO-2]);
    assign els  = c0_q[`TMC_C0_ELS_HI-2:`TMC_C0_ELS_LO-2];
    // Edge select 00 leaves the pin to general I/O: no capture
    assign cap_evt = (mode == tmc_pkg::TMC_CH_CAPTURE) &&
                     ((els[0] && CH0_PIN_IN && !pin_q) ||
                      (els[1] && !CH0_PIN_IN && pin_q));
    // Center mode matches on both slopes of the count
    assign ch_evt = cap_evt || ((mode != tmc_pkg::TMC_CH_CAPTURE) &&
                    moved_q && (cnt_q == chv_q));

    // Pin history and channel value, captures overwrite the value
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            pin_q <= 1'b0;
            chv_q <= `TMC_RST_WORD;
        end else if (CE_IN) begin
            pin_q <= CH0_PIN_IN;
            if (cap_evt) begin
                chv_q <= cnt_q;
            end else if (wr && hit(PADDR_IN, `TMC_IDX_C0V_HI)) begin
                chv_q[15:8] <= wd;
            end else if (wr && hit(PADDR_IN, `TMC_IDX_C0V_LO)) begin
                chv_q[7:0] <= wd;
            end
        end
    end

    // Channel control and flag; a new event restarts the clear
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            c0_q     <= 5'h00;
            channel_zero_event_flag_q   <= 1'b0;
            ch_arm_q <= 1'b0;
        end else if (CE_IN) begin
            if (c0_wr) begin
                c0_q <= wd[6:2];
            end
            if (ch_evt) begin
                channel_zero_event_flag_q <= 1'b1;
            end else if (c0_wr && !wd[`TMC_C0_FLAG] && ch_arm_q) begin
                channel_zero_event_flag_q <= 1'b0;
            end
            if (ch_evt || c0_wr) begin
                ch_arm_q <= 1'b0;
            end else if (rd && hit(PADDR_IN, `TMC_IDX_C0SC) && channel_zero_event_flag_q) begin
                ch_arm_q <= 1'b1;
            end
        end
    end

    assign CH0_IRQ_OUT = channel_zero_event_flag_q && c0_q[`TMC_C0_IE-2];

    ////////////////////////////////////////////////////////////////////
    // Checks

    AST_CNT_CLEAR: assert property (@(posedge CORE_CLK_IN)
        disable iff (!NRST_IN) (cnt_wr && CE_IN) |=> (cnt_q == 16'h0000))
        else $error("counter not cleared by byte write");

    AST_LATCH: assert property (@(posedge CORE_CLK_IN)
        disable iff (!NRST_IN)
        (rd_hi && !latched_q && !halt && CE_IN)
        |=> (latched_q && buf_q == $past(snap_q)))
        else $error("counter pair not latched on read");

    AST_RELEASE: assert property (@(posedge CORE_CLK_IN)
        disable iff (!NRST_IN) (sc_wr && CE_IN) |=> !latched_q)
        else $error("buffer not released by status write");

    AST_HALT: assert property (@(posedge CORE_CLK_IN)
        disable iff (!NRST_IN)
        (halt && !cnt_wr && !sc_wr)
        |=> ($stable(cnt_q) && $stable(latched_q)))
        else $error("counter or buffer moved in halt");

    AST_WRAP: assert property (@(posedge CORE_CLK_IN)
        disable iff (!NRST_IN)
        (CE_IN && tick && !halt && reach && !center_aligned_select && !cnt_wr)
        |=> (cnt_q == 16'h0000))
        else $error("counter did not wrap at modulo");

    AST_INHIBIT: assert property (@(posedge CORE_CLK_IN)
        disable iff (!NRST_IN)
        (CE_IN && mod_wait_q != 2'b00 && !tof_q) |=> !tof_q)
        else $error("overflow flagged with half modulo");

    AST_CH_KEEP: assert property (@(posedge CORE_CLK_IN)
        disable iff (!NRST_IN) (ch_evt && CE_IN) |=> channel_zero_event_flag_q)
        else $error("channel event lost");

    AST_TOF_W1: assert property (@(posedge CORE_CLK_IN)
        disable iff (!NRST_IN)
        (CE_IN && !tof_q && !ovf_evt) |=> !tof_q)
        else $error("overflow flag set without event");

    AST_CH_IRQ: assert property (@(posedge CORE_CLK_IN)
        disable iff (!NRST_IN)
        (CE_IN && c0_wr && wd[`TMC_C0_IE] && channel_zero_event_flag_q && !ch_arm_q)
        |=> CH0_IRQ_OUT)
        else $error("channel request missing");

endmodule

// ### common/tmc_consts.svh
// Register indices, field positions, reset values and timing for the timer
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// Register indices (byte address is four times the index)
`define TMC_IDX_SC      8'h10
`define TMC_IDX_CNT_HI  8'h11
`define TMC_IDX_CNT_LO  8'h12
`define TMC_IDX_MOD_HI  8'h13
`define TMC_IDX_MOD_LO  8'h14
`define TMC_IDX_C0SC    8'h15
`define TMC_IDX_C0V_HI  8'h16
`define TMC_IDX_C0V_LO  8'h17

// Module status and control fields
`define TMC_SC_TOF      7
`define TMC_SC_OVERFLOW_INTERRUPT_ENABLE     6
`define TMC_SC_CENTER_ALIGNED_SELECT    5
`define TMC_SC_CLKS_HI  4
`define TMC_SC_CLKS_LO  3
`define TMC_SC_PS_HI    2

// Channel zero control fields
`define TMC_C0_FLAG     7
`define TMC_C0_IE       6
`define TMC_C0_MS_HI    5
`define TMC_C0_MS_LO    4
`define TMC_C0_ELS_HI   3
`define TMC_C0_ELS_LO   2

// Reset values and count limits
`define TMC_RST_BYTE    8'h00
`define TMC_RST_WORD    16'h0000
`define TMC_CNT_FULL    16'hFFFF
`define TMC_CNT_ONE     16'h0001
`define TMC_PS_MAX_W    7

`endif

// ### common/tmc_pkg.sv
// Types shared by the timer counter design
package tmc_pkg;

    // Counting direction
    typedef enum logic {
        TMC_UP,
        TMC_DOWN
    } tmc_dir_t;

    // Channel zero operating mode
    typedef enum logic [1:0] {
        TMC_CH_CAPTURE,
        TMC_CH_COMPARE,
        TMC_CH_CENTER
    } tmc_chmode_t;

endpackage

// ### hw/tmc_tick.sv
// Prescaled tick generator for the timer counter
`timescale 1ns/1ps
`include "tmc_consts.svh"

module tmc_tick #(
    parameter int DIV_W = `TMC_PS_MAX_W
) (
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       ce_in,
    input  wire logic       run_in,
    input  wire logic [2:0] ps_in,
    output logic            tick_out
);

    logic [DIV_W-1:0] div_q;   // Free prescaler count
    logic [DIV_W-1:0] mask;    // Low bits that must all be set

    // Divide by two to the power ps: all low bits set marks the wrap
    assign mask = DIV_W'((1 << ps_in) - 1);

    ////////////////////////////////////////////////////////////////////
    // Prescaler count, stopped while no source or halted
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            div_q <= '0;
        end else if (ce_in && run_in) begin
            div_q <= div_q + 1'b1;
        end
    end

    // Registered tick, one cycle per divided period
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            tick_out <= 1'b0;
        end else if (ce_in) begin
            tick_out <= run_in && ((div_q & mask) == mask);
        end
    end

endmodule

// ### test/tmc_tb_top.sv
// Self-checking bench for the timer counter over its register bus
`timescale 1ns/1ps
`include "tmc_consts.svh"

module tmc_tb_top;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [31:0] ZERO = 32'h0000_0000; // Expected low flag
    localparam logic [31:0] ONE  = 32'h0000_0001; // Expected high flag

    logic        clk     = 1'b0;  // Core clock, 200 MHz
    logic        nrst    = 1'b0;  // Active low reset
    logic        psel    = 1'b0;  // Bus select
    logic        penable = 1'b0;  // Bus access phase
    logic        pwrite  = 1'b0;  // Bus direction
    logic [7:0]  paddr   = 8'h00; // Bus byte address
    logic [31:0] pwdata  = ZERO;  // Bus write data
    logic        halt    = 1'b0;  // Debug halt request
    logic        ce      = 1'b1;  // Clock enable
    logic        pin     = 1'b0;  // Channel zero pin
    logic        pready;          // Slave ready
    logic [31:0] prdata;          // Slave read data
    logic        pslverr;         // Slave error
    logic        ovf;             // Overflow request
    logic        ch0;             // Channel zero request
    logic [31:0] rd;              // Last read data
    logic        er;              // Last error response
    logic [7:0]  lo;              // Low byte kept between reads
    logic [15:0] cnt;             // Assembled counter pair
    int          err_count  = 0;  // Mismatches seen
    int          num_checks = 0;  // Comparisons made

    // Half period inversion gives 5 ns period
    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    // Clock enable drops once mid-count to show the freeze
    tmc_top #(.ADDR_W(8)) i_tmc_top (
        .CORE_CLK_IN   (clk),
        .NRST_IN       (nrst),
        .CE_IN         (ce),
        .PSEL_IN       (psel),
        .PENABLE_IN    (penable),
        .PWRITE_IN     (pwrite),
        .PADDR_IN      (paddr),
        .PWDATA_IN     (pwdata),
        .DEBUG_HALT_IN (halt),
        .CH0_PIN_IN    (pin),
        .PREADY_OUT    (pready),
        .PRDATA_OUT    (prdata),
        .PSLVERR_OUT   (pslverr),
        .OVF_IRQ_OUT   (ovf),
        .CH0_IRQ_OUT   (ch0)
    );

    ////////////////////////////////////////////////////////////////////////
    // One bus transfer; an idle edge follows so strobes never bounce
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [7:0] wd);
        logic [9:0] a;
        a = {idx, 2'b00};
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a[7:0];
        pwdata  <= {24'h00_0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Read then compare
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask

    // Low byte first, then high byte, into cnt
    task automatic rdcnt();
        apb(1'b0, `TMC_IDX_CNT_LO, 8'h00);
        lo = rd[7:0];
        apb(1'b0, `TMC_IDX_CNT_HI, 8'h00);
        cnt = {rd[7:0], lo};
    endtask

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, several times the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdchk(`TMC_IDX_SC, ZERO);
        rdchk(`TMC_IDX_CNT_HI, ZERO);
        rdchk(`TMC_IDX_CNT_LO, ZERO);
        rdchk(`TMC_IDX_MOD_HI, ZERO);
        rdchk(`TMC_IDX_MOD_LO, ZERO);
        rdchk(`TMC_IDX_C0SC, ZERO);
        $display("test reset values done");
        // Free running; buffer must hide the high byte rollover
        apb(1'b1, `TMC_IDX_SC, 8'h08);
        apb(1'b1, `TMC_IDX_CNT_HI, 8'h5A);
        apb(1'b0, `TMC_IDX_CNT_LO, 8'h00);
        check({31'h0, rd < 32'h0000_0010}, ONE);
        // Enable low for 300 edges must not add to the count
        repeat (150) @(posedge clk);
        ce <= 1'b0;
        repeat (300) @(posedge clk);
        ce <= 1'b1;
        repeat (150) @(posedge clk);
        rdchk(`TMC_IDX_CNT_HI, ZERO);
        rdcnt();
        check({24'h00_0000, cnt[15:8]}, ONE);
        $display("test coherent read done");
        // Frozen while halted
        halt <= 1'b1;
        apb(1'b0, `TMC_IDX_CNT_LO, 8'h00);
        lo = rd[7:0];
        repeat (40) @(posedge clk);
        rdchk(`TMC_IDX_CNT_LO, {24'h00_0000, lo});
        halt <= 1'b0;
        $display("test debug halt done");
        // Modulo 0x0100 with overflow request enabled, counter cleared first
        apb(1'b1, `TMC_IDX_CNT_LO, 8'h00);
        apb(1'b1, `TMC_IDX_MOD_HI, 8'h01);
        apb(1'b1, `TMC_IDX_MOD_LO, 8'h00);
        apb(1'b1, `TMC_IDX_SC, 8'h48);
        repeat (300) @(posedge clk);
        check({31'h0, ovf}, ONE);
        rdchk(`TMC_IDX_SC, 32'h0000_00C8);
        apb(1'b1, `TMC_IDX_SC, 8'h48);
        check({31'h0, ovf}, ZERO);
        apb(1'b1, `TMC_IDX_SC, 8'hC8);
        check({31'h0, ovf}, ZERO);
        rdcnt();
        check({31'h0, cnt <= 16'h0100}, ONE);
        // Half written modulo holds the flag off
        apb(1'b1, `TMC_IDX_MOD_HI, 8'h01);
        apb(1'b1, `TMC_IDX_CNT_LO, 8'h00);
        repeat (600) @(posedge clk);
        check({31'h0, ovf}, ZERO);
        apb(1'b1, `TMC_IDX_MOD_LO, 8'h00);
        repeat (300) @(posedge clk);
        check({31'h0, ovf}, ONE);
        $display("test modulo done");
        // Compare match at 0x0010
        apb(1'b1, `TMC_IDX_C0V_HI, 8'h00);
        apb(1'b1, `TMC_IDX_C0V_LO, 8'h10);
        apb(1'b1, `TMC_IDX_C0SC, 8'h50);
        apb(1'b1, `TMC_IDX_CNT_LO, 8'h00);
        repeat (40) @(posedge clk);
        check({31'h0, ch0}, ONE);
        apb(1'b0, `TMC_IDX_C0SC, 8'h00);
        apb(1'b1, `TMC_IDX_C0SC, 8'h50);
        check({31'h0, ch0}, ZERO);
        // A match between arming read and clearing write keeps the flag
        repeat (300) @(posedge clk);
        apb(1'b0, `TMC_IDX_C0SC, 8'h00);
        repeat (300) @(posedge clk);
        apb(1'b1, `TMC_IDX_C0SC, 8'h50);
        check({31'h0, ch0}, ONE);
        // Enable off masks the request, flag still readable
        apb(1'b1, `TMC_IDX_C0SC, 8'h10);
        check({31'h0, ch0}, ZERO);
        rdchk(`TMC_IDX_C0SC, 32'h0000_0090);
        $display("test compare done");
        // Rising edge capture
        apb(1'b0, `TMC_IDX_C0SC, 8'h00);
        apb(1'b1, `TMC_IDX_C0SC, 8'h44);
        check({31'h0, ch0}, ZERO);
        pin <= 1'b1;
        repeat (5) @(posedge clk);
        check({31'h0, ch0}, ONE);
        // Falling edge capture after a clean flag clear
        apb(1'b0, `TMC_IDX_C0SC, 8'h00);
        apb(1'b1, `TMC_IDX_C0SC, 8'h48);
        check({31'h0, ch0}, ZERO);
        pin <= 1'b0;
        repeat (5) @(posedge clk);
        check({31'h0, ch0}, ONE);
        $display("test capture done");
        // Up/down at divide by two: past the limit the count falls back
        apb(1'b1, `TMC_IDX_SC, 8'h29);
        apb(1'b1, `TMC_IDX_CNT_LO, 8'h00);
        repeat (600) @(posedge clk);
        rdcnt();
        check({31'h0, cnt > 16'h0080 && cnt < 16'h0100}, ONE);
        $display("test center mode done");
        // Unmapped index is refused
        apb(1'b0, 8'h18, 8'h00);
        check({31'h0, er}, ONE);
        $display("test unmapped done");
        tally_and_finish();
    end

endmodule
